// ---- core/pkt_gen_checker.sv ----
// Packet generator and CRC checker with an AXI4-Lite register slave.
`timescale 1ns/100ps
// Notes on behaviour
// - Burst field zero sends forever; otherwise exactly that many packets.
// - Generator select 000 disables; 010 copper, 100 SGMII, 110 RGMII.
// - Trigger bit acts only with select nonzero, self-clear 1, burst nonzero.
// - Trigger bit reads 1 when burst is done, 0 while transmitting.
// - Writing 0 while it reads 1 restarts; writes while 0 are ignored.
// - Self-clear 0 clears select after the burst; 1 keeps it.
// - Payload select 0 is pseudo-random, 1 is alternating 5A and A5.
// - Length bit set gives 1518-byte frames, clear gives 64-byte frames.
// - Error bit sends frames with bad CRC and a symbol error.
// - Received packet count is 8 bits, read-only, saturating at FF.
// - CRC error count is 8 bits, read-only, saturating at FF.
// - Checker counters are valid only while checker select is nonzero.
// - Writing 1 to counter reset clears both counters; bit self-clears.
// - Checker select 000 disables and resets; 010, 100, 110 pick a path.
// - Gap between frames is gap field plus one bytes; reset value 0xC.
module pkt_gen_checker (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write channels
  input  wire logic [pktgen_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  // AXI4-Lite read channels
  input  wire logic [pktgen_pkg::ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // Receive byte streams of the three paths
  input  wire pktgen_pkg::byte_strm_t       rx_copper,
  input  wire pktgen_pkg::byte_strm_t       rx_sgmii,
  input  wire pktgen_pkg::byte_strm_t       rx_rgmii,
  // Generated byte stream and its target path
  output pktgen_pkg::byte_strm_t            tx_stream,
  output logic [2:0]                        tx_path,
  // Interrupt
  output logic                              irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                         awready;
    logic                         wready;
    logic                         aw_got;
    logic                         w_got;
    logic [pktgen_pkg::ADDR_W-1:0] waddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic [15:0]                  gen;
    logic [15:0]                  chk;
    logic [15:0]                  ipg;
    logic [pktgen_pkg::IRQ_W-1:0] ist;
    logic [pktgen_pkg::IRQ_W-1:0] imsk;
    logic                         irq;
    logic                         done;
    pktgen_pkg::gen_state_t       gst;
    logic [10:0]                  bcnt;
    logic [7:0]                   gcnt;
    logic [7:0]                   sent;
    logic [15:0]                  lfsr;
    logic [31:0]                  crc;
    pktgen_pkg::byte_strm_t       tx;
    logic [2:0]                   path;
    logic [31:0]                  rcrc;
    logic [7:0]                   pkt_cnt;
    logic [7:0]                   err_cnt;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Reflected CRC-32 over one byte, shared by generator and checker.
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ pktgen_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Only the three documented path codes select a path.
  function automatic logic path_ok(input logic [2:0] p);
    return (p == pktgen_pkg::PATH_COPPER) || (p == pktgen_pkg::PATH_SGMII) ||
           (p == pktgen_pkg::PATH_RGMII);
  endfunction

  // Byte-lane merge of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = d[7:0];
    end
    if (st[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Saturating 8-bit increment; the counters never wrap.
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == pktgen_pkg::CNT_MAX) ? v : v + 8'h01;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic [15:0]            wd;
  logic [2:0]             gsel;
  logic [2:0]             csel;
  logic [7:0]             burst;
  logic [10:0]            flen;
  logic [10:0]            pay;
  logic [1:0]             fidx;
  logic [31:0]            fcs;
  logic [7:0]             gbyte;
  logic [31:0]            rc;
  pktgen_pkg::byte_strm_t rx;
  logic                   cclr;

  // One process computes every register's next value in a fixed order:
  // bus writes first, hardware events next and the counter reset last, so a status set beats a clear.
  always_comb begin
    nxt_s = s_ff;
    wd    = 16'h0000;
    gsel  = s_ff.gen[pktgen_pkg::GEN_SEL_LSB +: 3];
    burst = s_ff.gen[pktgen_pkg::GEN_BURST_LSB +: 8];
    csel  = s_ff.chk[pktgen_pkg::CHK_SEL_LSB +: 3];
    flen  = s_ff.gen[pktgen_pkg::GEN_LEN_BIT] ? pktgen_pkg::LEN_LONG
                                              : pktgen_pkg::LEN_SHORT;
    pay   = flen - pktgen_pkg::FCS_BYTES;
    fidx  = 2'(s_ff.bcnt - pay);
    fcs   = ~s_ff.crc;
    gbyte = 8'h00;
    rc    = 32'h00000000;
    rx    = '0;
    cclr  = 1'b0;
    nxt_s.tx = '0;

    // Write address and data are taken in either order.
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.waddr  = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = wdata;
      nxt_s.wstrb = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end

    // A write is performed once both halves are held.
    if (s_ff.aw_got && s_ff.w_got) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = pktgen_pkg::RESP_OKAY;
      unique case (s_ff.waddr)
        pktgen_pkg::ADDR_GEN_CTRL: begin
          wd = merge16(s_ff.gen, s_ff.wdata, s_ff.wstrb);
          wd[pktgen_pkg::GEN_TRIG_BIT] = 1'b0;
          nxt_s.gen = wd;
          // A fresh select from 000 starts a new run.
          if (gsel == pktgen_pkg::PATH_OFF &&
              wd[pktgen_pkg::GEN_SEL_LSB +: 3] != pktgen_pkg::PATH_OFF) begin
            nxt_s.done = 1'b0;
            nxt_s.sent = 8'h00;
          end
          // Restart only from done, by a 0 on the trigger lane.
          if (s_ff.done && s_ff.wstrb[0] &&
              !s_ff.wdata[pktgen_pkg::GEN_TRIG_BIT] &&
              wd[pktgen_pkg::GEN_SEL_LSB +: 3] != pktgen_pkg::PATH_OFF &&
              wd[pktgen_pkg::GEN_SC_BIT] &&
              wd[pktgen_pkg::GEN_BURST_LSB +: 8] != 8'h00) begin
            nxt_s.done = 1'b0;
            nxt_s.sent = 8'h00;
          end
        end
        pktgen_pkg::ADDR_CHK_CTRL: begin
          wd = merge16(s_ff.chk, s_ff.wdata, s_ff.wstrb);
          cclr = wd[pktgen_pkg::CHK_CLR_BIT];
          wd[pktgen_pkg::CHK_CLR_BIT] = 1'b0;
          nxt_s.chk = wd;
        end
        pktgen_pkg::ADDR_IPG: begin
          nxt_s.ipg = merge16(s_ff.ipg, s_ff.wdata, s_ff.wstrb);
        end
        pktgen_pkg::ADDR_IRQ_STAT: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ist = s_ff.ist & ~s_ff.wdata[pktgen_pkg::IRQ_W-1:0];
          end
        end
        pktgen_pkg::ADDR_IRQ_MASK: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.imsk = s_ff.wdata[pktgen_pkg::IRQ_W-1:0];
          end
        end
        pktgen_pkg::ADDR_CHK_CNT: begin
          // Read-only; the write is accepted and dropped.
        end
        default: begin
          nxt_s.bresp = pktgen_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = pktgen_pkg::RESP_OKAY;
      nxt_s.rdata  = 32'h00000000;
      unique case (araddr)
        pktgen_pkg::ADDR_GEN_CTRL: begin
          nxt_s.rdata[15:0] = s_ff.gen;
          nxt_s.rdata[pktgen_pkg::GEN_TRIG_BIT] = s_ff.done;
        end
        pktgen_pkg::ADDR_CHK_CNT: begin
          nxt_s.rdata[15:0] = {s_ff.pkt_cnt, s_ff.err_cnt};
        end
        pktgen_pkg::ADDR_CHK_CTRL: nxt_s.rdata[15:0] = s_ff.chk;
        pktgen_pkg::ADDR_IPG:      nxt_s.rdata[15:0] = s_ff.ipg;
        pktgen_pkg::ADDR_IRQ_STAT: nxt_s.rdata[pktgen_pkg::IRQ_W-1:0] = s_ff.ist;
        pktgen_pkg::ADDR_IRQ_MASK: nxt_s.rdata[pktgen_pkg::IRQ_W-1:0] = s_ff.imsk;
        default:                   nxt_s.rresp = pktgen_pkg::RESP_SLVERR;
      endcase
    end

    // ---------------------------------------------------------------
    // Generator
    // ---------------------------------------------------------------
    // The path is latched per frame, so a select change mid-frame never
    // truncates the frame on the wire.
    unique case (s_ff.gst)
      pktgen_pkg::GEN_IDLE: begin
        if (path_ok(gsel) && !s_ff.done) begin
          nxt_s.gst  = pktgen_pkg::GEN_SEND;
          nxt_s.bcnt = 11'h000;
          nxt_s.crc  = pktgen_pkg::CRC_INIT;
          nxt_s.path = gsel;
        end
      end
      pktgen_pkg::GEN_SEND: begin
        if (s_ff.bcnt < pay) begin
          gbyte = s_ff.gen[pktgen_pkg::GEN_PAT_BIT] ?
                  (s_ff.bcnt[0] ? pktgen_pkg::PAT_ODD : pktgen_pkg::PAT_EVEN)
                  : s_ff.lfsr[7:0];
          nxt_s.lfsr = {s_ff.lfsr[14:0], s_ff.lfsr[15] ^ s_ff.lfsr[13] ^
                        s_ff.lfsr[12] ^ s_ff.lfsr[10]};
          nxt_s.crc  = crc_byte(s_ff.crc, gbyte);
        end else begin
          gbyte = fcs[8 * fidx +: 8];
          if (s_ff.gen[pktgen_pkg::GEN_ERR_BIT]) begin
            gbyte = ~gbyte;
          end
        end
        nxt_s.tx.valid = 1'b1;
        nxt_s.tx.data  = gbyte;
        nxt_s.tx.last  = (s_ff.bcnt == flen - 11'h001);
        nxt_s.tx.err   = nxt_s.tx.last &&
                         s_ff.gen[pktgen_pkg::GEN_ERR_BIT];
        nxt_s.bcnt     = s_ff.bcnt + 11'h001;
        if (nxt_s.tx.last) begin
          nxt_s.gst  = pktgen_pkg::GEN_GAP;
          nxt_s.gcnt = 8'h00;
          nxt_s.sent = s_ff.sent + 8'h01;
          // A zero burst field never finishes.
          if (burst != 8'h00 && s_ff.sent + 8'h01 == burst) begin
            nxt_s.done = 1'b1;
            nxt_s.ist[pktgen_pkg::IRQ_DONE_BIT] = 1'b1;
            if (!s_ff.gen[pktgen_pkg::GEN_SC_BIT]) begin
              nxt_s.gen[pktgen_pkg::GEN_SEL_LSB +: 3] = pktgen_pkg::PATH_OFF;
            end
          end
        end
      end
      pktgen_pkg::GEN_GAP: begin
        nxt_s.gcnt = s_ff.gcnt + 8'h01;
        // The gap ends after field plus one idle byte times; the next
        // frame follows directly, with no extra idle cycle.
        if (s_ff.gcnt == s_ff.ipg[7:0]) begin
          nxt_s.gst = pktgen_pkg::GEN_IDLE;
          if (path_ok(gsel) && !s_ff.done) begin
            nxt_s.gst  = pktgen_pkg::GEN_SEND;
            nxt_s.bcnt = 11'h000;
            nxt_s.crc  = pktgen_pkg::CRC_INIT;
            nxt_s.path = gsel;
          end
        end
      end
    endcase

    // ---------------------------------------------------------------
    // Checker
    // ---------------------------------------------------------------
    unique case (csel)
      pktgen_pkg::PATH_COPPER: rx = rx_copper;
      pktgen_pkg::PATH_SGMII:  rx = rx_sgmii;
      pktgen_pkg::PATH_RGMII:  rx = rx_rgmii;
      default:                 rx = '0;
    endcase
    rc = crc_byte(s_ff.rcrc, rx.data);
    if (csel == pktgen_pkg::PATH_OFF) begin
      nxt_s.pkt_cnt = 8'h00;
      nxt_s.err_cnt = 8'h00;
      nxt_s.rcrc    = pktgen_pkg::CRC_INIT;
    end else if (rx.valid) begin
      nxt_s.rcrc = rc;
      if (rx.last) begin
        nxt_s.rcrc    = pktgen_pkg::CRC_INIT;
        nxt_s.pkt_cnt = sat_inc(nxt_s.pkt_cnt);
        if (rc != pktgen_pkg::CRC_RESIDUE) begin
          nxt_s.err_cnt = sat_inc(nxt_s.err_cnt);
          nxt_s.ist[pktgen_pkg::IRQ_CRC_BIT] = 1'b1;
        end
      end
    end
    // A counter reset beats a frame counted in the same cycle, so the
    // counters always read zero right after software asks for it.
    if (cclr) begin
      nxt_s.pkt_cnt = 8'h00;
      nxt_s.err_cnt = 8'h00;
    end

    // Ready and interrupt outputs are registered copies of next state.
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready  = !nxt_s.w_got && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;
    nxt_s.irq     = |(nxt_s.ist & nxt_s.imsk);
  end

  // Registers every field; reset gives constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff      <= '0;
      s_ff.gen  <= pktgen_pkg::GEN_RST;
      s_ff.chk  <= pktgen_pkg::CHK_RST;
      s_ff.ipg  <= pktgen_pkg::IPG_RST;
      s_ff.lfsr <= pktgen_pkg::LFSR_SEED;
      s_ff.crc  <= pktgen_pkg::CRC_INIT;
      s_ff.rcrc <= pktgen_pkg::CRC_INIT;
      s_ff.gst  <= pktgen_pkg::GEN_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign awready   = s_ff.awready;
  assign wready    = s_ff.wready;
  assign bvalid    = s_ff.bvalid;
  assign bresp     = s_ff.bresp;
  assign arready   = s_ff.arready;
  assign rvalid    = s_ff.rvalid;
  assign rdata     = s_ff.rdata;
  assign rresp     = s_ff.rresp;
  assign tx_stream = s_ff.tx;
  assign tx_path   = s_ff.path;
  assign irq       = s_ff.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLR_GUARD = pktgen_pkg::ADDR_CHK_CTRL;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_pkt_saturate: assert property (
    $past(s_ff.pkt_cnt) == pktgen_pkg::CNT_MAX &&
    $past(s_ff.chk[2:0]) != 3'h0 && $past(s_ff.waddr) != ADDR_CLR_GUARD
    |-> s_ff.pkt_cnt == pktgen_pkg::CNT_MAX)
    else $error("Packet count left its maximum.");
  chk_err_saturate: assert property (
    $past(s_ff.err_cnt) == pktgen_pkg::CNT_MAX &&
    $past(s_ff.chk[2:0]) != 3'h0 && $past(s_ff.waddr) != ADDR_CLR_GUARD
    |-> s_ff.err_cnt == pktgen_pkg::CNT_MAX)
    else $error("Error count left its maximum.");
  chk_frame_length: assert property (
    s_ff.tx.valid && s_ff.tx.last |->
    s_ff.bcnt == (s_ff.gen[1] ? pktgen_pkg::LEN_LONG : pktgen_pkg::LEN_SHORT))
    else $error("Frame ended at the wrong length.");
  chk_gap_length: assert property (
    s_ff.gst == pktgen_pkg::GEN_GAP ##1 s_ff.gst != pktgen_pkg::GEN_GAP
    |-> $past(s_ff.gcnt) == $past(s_ff.ipg[7:0]) && !s_ff.tx.valid)
    else $error("Gap ended early.");
  chk_burst_done: assert property (
    $rose(s_ff.done) |-> s_ff.sent == s_ff.gen[15:8] && s_ff.sent != 8'h00)
    else $error("Burst finished at the wrong count.");
  chk_sel_clear: assert property (
    $rose(s_ff.done) && !s_ff.gen[3] |-> s_ff.gen[7:5] == 3'h0)
    else $error("Select not cleared after burst.");
  chk_cnt_reset: assert property (
    s_ff.aw_got && s_ff.w_got && s_ff.waddr == pktgen_pkg::ADDR_CHK_CTRL &&
    s_ff.wstrb[0] && s_ff.wdata[4]
    |=> s_ff.pkt_cnt == 8'h00 && s_ff.err_cnt == 8'h00 && !s_ff.chk[4])
    else $error("Counter reset did not clear.");
  chk_off_reset: assert property (
    s_ff.chk[2:0] == 3'h0 ##1 s_ff.chk[2:0] == 3'h0
    |-> s_ff.pkt_cnt == 8'h00 && s_ff.err_cnt == 8'h00)
    else $error("Counters held while checker off.");
  chk_pattern_byte: assert property (
    $past(s_ff.gst) == pktgen_pkg::GEN_SEND && $past(s_ff.gen[2]) &&
    $past(s_ff.bcnt) < 11'h03C
    |-> s_ff.tx.data == ($past(s_ff.bcnt[0]) ? 8'hA5 : 8'h5A))
    else $error("Fixed pattern byte wrong.");
  chk_symbol_err: assert property (
    s_ff.tx.valid && s_ff.tx.last |-> s_ff.tx.err == $past(s_ff.gen[0]))
    else $error("Symbol error flag mismatch.");

endmodule

// ---- dv/path_loop.sv ----
// Loopback model of the three receive data paths.
`timescale 1ns/100ps
module path_loop (
  // Generated stream and its target path
  input  wire pktgen_pkg::byte_strm_t tx,
  input  wire logic [2:0]             path,
  // Streams handed back to the checker
  output pktgen_pkg::byte_strm_t      rx_c,
  output pktgen_pkg::byte_strm_t      rx_s,
  output pktgen_pkg::byte_strm_t      rx_r
);
  // An unselected path shows inverted data, so no stale byte passes.
  function automatic pktgen_pkg::byte_strm_t pick(
    input pktgen_pkg::byte_strm_t t, input logic [2:0] p, q);
    pick = t;
    if (p != q) begin
      pick.valid = 1'b0;
      pick.data  = ~t.data;
    end
  endfunction
  // Each path carries only what the generator aims at it.
  assign rx_c = pick(tx, path, pktgen_pkg::PATH_COPPER);
  assign rx_s = pick(tx, path, pktgen_pkg::PATH_SGMII);
  assign rx_r = pick(tx, path, pktgen_pkg::PATH_RGMII);
endmodule

// ---- dv/tb_pkt_gen_checker.sv ----
// Self-checking bench of the packet generator and checker.
`timescale 1ns/100ps
module tb_pkt_gen_checker;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
  logic rvalid, irq, errlast;
  logic [7:0] awaddr = 0, araddr = 0, first;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [2:0] tx_path;
  pktgen_pkg::byte_strm_t rx_c, rx_s, rx_r, tx;
  int fail_count = 0, total_checks = 0, flen = 0, gap = 0;
  int lastlen, lastgap;
  pkt_gen_checker pkt_gen_checker_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_copper(rx_c), .rx_sgmii(rx_s), .rx_rgmii(rx_r),
    .tx_stream(tx), .tx_path(tx_path), .irq(irq));
  path_loop path_loop_i (.tx(tx), .path(tx_path), .rx_c(rx_c),
    .rx_s(rx_s), .rx_r(rx_r));
  // Clock of 20 ns.
  always #10 aclk = ~aclk;
  // Frame length, first byte, last-byte error and gap of the stream.
  always @(posedge aclk) begin
    if (tx.valid) begin
      if (flen == 0) begin
        first <= tx.data;
        lastgap <= gap;
      end
      flen <= flen + 1;
      gap <= 0;
      if (tx.last) begin
        lastlen <= flen + 1;
        errlast <= tx.err;
        flen <= 0;
      end
    end else gap <= gap + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address and data go out together; each drops when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    // Each channel drops at the edge where its own ready is seen high.
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp, input logic [1:0] rs);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0; rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(nm, rdata, exp);
    chk("rresp", {30'h0, rresp}, {30'h0, rs});
  endtask
  // Bounded wait for the done interrupt, then clear the status.
  task automatic wait_done;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin @(posedge aclk); n++; end
    chk("irq", {31'h0, irq}, 32'h1);
    wr(pktgen_pkg::ADDR_IRQ_STAT, 32'h3);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_reset;
    rdchk("gen", pktgen_pkg::ADDR_GEN_CTRL, 32'h0, 2'h0);
    rdchk("ipg", pktgen_pkg::ADDR_IPG, 32'hC, 2'h0);
    wr(pktgen_pkg::ADDR_CHK_CNT, 32'hFFFF);
    rdchk("cnt", pktgen_pkg::ADDR_CHK_CNT, 32'h0, 2'h0);
    rdchk("hole", 8'h60, 32'h0, pktgen_pkg::RESP_SLVERR);
    wr(pktgen_pkg::ADDR_IRQ_MASK, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_burst;
    wr(pktgen_pkg::ADDR_CHK_CTRL, 32'h2);
    wr(pktgen_pkg::ADDR_GEN_CTRL, 32'h0244);
    wait_done();
    rdchk("gen", pktgen_pkg::ADDR_GEN_CTRL, 32'h0214, 2'h0);
    rdchk("cnt", pktgen_pkg::ADDR_CHK_CNT, 32'h0200, 2'h0);
    chk("first", {24'h0, first}, 32'h5A);
    chk("len", lastlen, 32'd64);
    chk("gap", lastgap, 32'd13);
    $display("burst test done");
  endtask
  task automatic t_error;
    wr(pktgen_pkg::ADDR_CHK_CTRL, 32'h16);
    rdchk("cctl", pktgen_pkg::ADDR_CHK_CTRL, 32'h6, 2'h0);
    rdchk("cnt", pktgen_pkg::ADDR_CHK_CNT, 32'h0, 2'h0);
    wr(pktgen_pkg::ADDR_GEN_CTRL, 32'h01C9);
    wait_done();
    rdchk("cnt", pktgen_pkg::ADDR_CHK_CNT, 32'h0101, 2'h0);
    chk("err", {31'h0, errlast}, 32'h1);
    chk("path", {29'h0, tx_path}, 32'h6);
    rdchk("gen", pktgen_pkg::ADDR_GEN_CTRL, 32'h01D9, 2'h0);
    $display("error test done");
  endtask
  task automatic t_restart;
    wr(pktgen_pkg::ADDR_GEN_CTRL, 32'h01C8);
    wait_done();
    rdchk("cnt", pktgen_pkg::ADDR_CHK_CNT, 32'h0201, 2'h0);
    wr(pktgen_pkg::ADDR_GEN_CTRL, 32'h01D8);
    rdchk("gen", pktgen_pkg::ADDR_GEN_CTRL, 32'h01D8, 2'h0);
    wr(pktgen_pkg::ADDR_CHK_CTRL, 32'h0);
    rdchk("cnt", pktgen_pkg::ADDR_CHK_CNT, 32'h0, 2'h0);
    $display("restart test done");
  endtask
  // Main sequence: reset for 16 cycles, then the scenarios.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_burst();
    t_error();
    t_restart();
    stop_test();
  end
  // Whole run takes well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    stop_test();
  end
endmodule

// ---- include/pktgen_pkg.sv ----
// Constants, register map and carrier types of the packet generator and checker.
package pktgen_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  IDX_GEN_CTRL = 8'h10;
  localparam logic [7:0]  IDX_CHK_CNT  = 8'h11;
  localparam logic [7:0]  IDX_CHK_CTRL = 8'h12;
  localparam logic [7:0]  IDX_IPG      = 8'h13;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'h14;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'h15;
  localparam logic [7:0]  ADDR_GEN_CTRL = {IDX_GEN_CTRL[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CHK_CNT  = {IDX_CHK_CNT[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CHK_CTRL = {IDX_CHK_CTRL[5:0], 2'b00};
  localparam logic [7:0]  ADDR_IPG      = {IDX_IPG[5:0], 2'b00};
  localparam logic [7:0]  ADDR_IRQ_STAT = {IDX_IRQ_STAT[5:0], 2'b00};
  localparam logic [7:0]  ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned GEN_BURST_LSB = 8;
  localparam int unsigned GEN_SEL_LSB   = 5;
  localparam int unsigned GEN_TRIG_BIT  = 4;
  localparam int unsigned GEN_SC_BIT    = 3;
  localparam int unsigned GEN_PAT_BIT   = 2;
  localparam int unsigned GEN_LEN_BIT   = 1;
  localparam int unsigned GEN_ERR_BIT   = 0;
  localparam int unsigned CHK_CLR_BIT   = 4;
  localparam int unsigned CHK_SEL_LSB   = 0;
  localparam int unsigned CNT_PKT_LSB   = 8;
  localparam int unsigned IRQ_DONE_BIT  = 0;
  localparam int unsigned IRQ_CRC_BIT   = 1;
  localparam int unsigned IRQ_W         = 2;
  localparam logic [15:0] GEN_RST       = 16'h0000;
  localparam logic [15:0] CHK_RST       = 16'h0000;
  localparam logic [15:0] IPG_RST       = 16'h000C;

  // ---------------------------------------------------------------
  // Path codes, frame shape and CRC constants
  // ---------------------------------------------------------------
  localparam logic [2:0]  PATH_OFF    = 3'h0;
  localparam logic [2:0]  PATH_COPPER = 3'h2;
  localparam logic [2:0]  PATH_SGMII  = 3'h4;
  localparam logic [2:0]  PATH_RGMII  = 3'h6;
  localparam logic [10:0] LEN_SHORT   = 11'h040;
  localparam logic [10:0] LEN_LONG    = 11'h5EE;
  localparam logic [10:0] FCS_BYTES   = 11'h004;
  localparam logic [7:0]  PAT_EVEN    = 8'h5A;
  localparam logic [7:0]  PAT_ODD     = 8'hA5;
  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       err;
  } byte_strm_t;

  typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_GAP} gen_state_t;

endpackage
